// ==== icw_regs.svh ====
`ifndef ICW_REGS_SVH
`define ICW_REGS_SVH
`define ICW_A_LOSS_RANGE 8'h01
`define ICW_A_TIME_CONST 8'h03
`define ICW_A_DIGITAL_CONVERSION_CONFIG 8'h04
`define ICW_A_ALT_CONF 8'h05
`define ICW_A_DRIVE_REPORT 8'h0C
`define ICW_A_STATUS 8'h20
`define ICW_A_REFERENCE_COUNT_LO 8'h30
`define ICW_A_REFERENCE_COUNT_HI 8'h31
`define ICW_A_OFFSET_LO 8'h32
`define ICW_A_OFFSET_HI 8'h33
`define ICW_A_HR_CONFIG 8'h34
`define ICW_A_RESULT_LO 8'h38
`define ICW_A_RESULT_MID 8'h39
`define ICW_A_RESULT_HI 8'h3A
`define ICW_LOSTFLAG_BIT 7
`define ICW_POST_CYCLES 24'h000037
`define ICW_RESULT_ALL_ONES 24'hFFFFFF
`define ICW_RESP_BASE 16'h00C0
`define ICW_WD_BASE 16'h0040
`define ICW_REF_TIMEOUT 8'hFF
`endif

// ==== icw_pkg.sv ====
package icw_pkg;
  typedef enum logic [1:0] {HR_IDLE, HR_COUNT, HR_POST} icw_hr_state_e;
  typedef logic [7:0] icw_byte_t;
endpackage

// ==== icw_edge_sync.sv ====
`include "icw_regs.svh"
// two-stage synchroniser with rising-edge pulse on the second stage
module icw_edge_sync (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic meta;
  logic sync;
  logic prev;
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end
  assign level_out = sync;
  assign rise_out = sync & ~prev;
endmodule // icw_edge_sync

// ==== icw_timing_watchdog.sv ====
`include "icw_regs.svh"
// Operation
// - watchdog sees no oscillation: set lost flag and restart oscillator
// - watchdog restart aborts any conversion in progress
// - watchdog interval set by lowest-frequency field, lower means longer
// - after oscillation loss the high-res result reads all ones while the reference clock runs
// - response-length field selects 192 to 6144 sensor cycles
// - loss-plus-inductance conversion lasts response length over three periods
// - without reference clock loss works and inductance results read zero
// - result at 0x38..0x3A, offset at 0x32..0x33, divider in 0x34 bits 1:0
// - sensor divider scales sensor frequency by two to its value
// - multi-byte values sit least significant byte first
// - zero result means fault or no conversion done yet
// - high-res conversion lasts 16 reference cycles per count plus 55
// - high-res conversion waits for a toggling reference clock
module icw_timing_watchdog (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sensor_osc_in,
  input wire logic reference_clock_input_in,
  output logic osc_restart_out,
  output logic loss_conv_done_out,
  output logic hr_conv_done_out,
  output logic [7:0] loss_range_out,
  output logic [7:0] time_constant_out,
  output logic fixed_drive_optimise_out,
  output logic drive_status_report_out
);
  logic [7:0] loss_range_setting, time_constant_setting, digital_conversion_config;
  logic [7:0] alternate_config, drive_report_config, high_res_config;
  logic [15:0] reference_count, result_offset;
  logic [23:0] high_res_result;
  logic oscillation_lost_flag;
  logic sens_rise, ref_rise;
  icw_edge_sync u_sens (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .async_in(sensor_osc_in), .level_out(), .rise_out(sens_rise));
  icw_edge_sync u_ref (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .async_in(reference_clock_input_in), .level_out(), .rise_out(ref_rise));

  // register file
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      loss_range_setting <= 8'h00;
      time_constant_setting <= 8'h00;
      digital_conversion_config <= 8'h00;
      alternate_config <= 8'h00;
      drive_report_config <= 8'h00;
      reference_count <= 16'h0000;
      result_offset <= 16'h0000;
      high_res_config <= 8'h00;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `ICW_A_LOSS_RANGE: loss_range_setting <= reg_wdata_in;
        `ICW_A_TIME_CONST: time_constant_setting <= reg_wdata_in;
        `ICW_A_DIGITAL_CONVERSION_CONFIG: digital_conversion_config <= reg_wdata_in;
        `ICW_A_ALT_CONF: alternate_config <= reg_wdata_in;
        `ICW_A_DRIVE_REPORT: drive_report_config <= reg_wdata_in;
        `ICW_A_REFERENCE_COUNT_LO: reference_count[7:0] <= reg_wdata_in;
        `ICW_A_REFERENCE_COUNT_HI: reference_count[15:8] <= reg_wdata_in;
        `ICW_A_OFFSET_LO: result_offset[7:0] <= reg_wdata_in;
        `ICW_A_OFFSET_HI: result_offset[15:8] <= reg_wdata_in;
        `ICW_A_HR_CONFIG: high_res_config <= {6'h00, reg_wdata_in[1:0]};
        default: ;
      endcase
    end
  end
  assign loss_range_out = loss_range_setting;
  assign time_constant_out = time_constant_setting;
  assign fixed_drive_optimise_out = alternate_config[0];
  assign drive_status_report_out = drive_report_config[0];

  always_comb
  begin
    case (reg_addr_in)
      `ICW_A_LOSS_RANGE: reg_rdata_out = loss_range_setting;
      `ICW_A_TIME_CONST: reg_rdata_out = time_constant_setting;
      `ICW_A_DIGITAL_CONVERSION_CONFIG: reg_rdata_out = digital_conversion_config;
      `ICW_A_ALT_CONF: reg_rdata_out = alternate_config;
      `ICW_A_DRIVE_REPORT: reg_rdata_out = drive_report_config;
      `ICW_A_STATUS: reg_rdata_out = {oscillation_lost_flag, 7'h00};
      `ICW_A_REFERENCE_COUNT_LO: reg_rdata_out = reference_count[7:0];
      `ICW_A_REFERENCE_COUNT_HI: reg_rdata_out = reference_count[15:8];
      `ICW_A_OFFSET_LO: reg_rdata_out = result_offset[7:0];
      `ICW_A_OFFSET_HI: reg_rdata_out = result_offset[15:8];
      `ICW_A_HR_CONFIG: reg_rdata_out = high_res_config;
      `ICW_A_RESULT_LO: reg_rdata_out = high_res_result[7:0];
      `ICW_A_RESULT_MID: reg_rdata_out = high_res_result[15:8];
      `ICW_A_RESULT_HI: reg_rdata_out = high_res_result[23:16];
      default: reg_rdata_out = 8'h00;
    endcase
  end

  // watchdog: core cycles without a sensor edge; lower field means longer wait
  logic [19:0] wd_cnt, next_wd_cnt, wd_limit;
  logic next_lost, restart, next_restart;
  assign wd_limit = {`ICW_WD_BASE, 4'h0} >> digital_conversion_config[7:4];
  always_comb
  begin
    next_wd_cnt = wd_cnt;
    next_lost = oscillation_lost_flag;
    next_restart = 1'b0;
    // a timeout wins over a coincident edge so a loss is never dropped
    if (wd_cnt >= wd_limit)
    begin
      next_wd_cnt = 20'h00000;
      next_lost = 1'b1;
      next_restart = 1'b1;
    end
    else if (sens_rise)
    begin
      next_wd_cnt = 20'h00000;
      next_lost = 1'b0;
    end
    else
      next_wd_cnt = wd_cnt + 20'h00001;
  end
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wd_cnt <= 20'h00000;
      oscillation_lost_flag <= 1'b0;
      restart <= 1'b0;
    end
    else
    begin
      wd_cnt <= next_wd_cnt;
      oscillation_lost_flag <= next_lost;
      restart <= next_restart;
    end
  end
  assign osc_restart_out = restart;

  // loss-plus-inductance conversion counts sensor cycles: response/3 periods
  logic [15:0] lp_cnt, next_lp_cnt, lp_len;
  logic lp_done, next_lp_done;
  logic [2:0] resp_sel;
  assign resp_sel = (digital_conversion_config[2:0] < 3'h2) ? 3'h2 : digital_conversion_config[2:0];
  assign lp_len = 16'((`ICW_RESP_BASE << (resp_sel - 3'h2)) / 16'h0003);
  always_comb
  begin
    next_lp_cnt = lp_cnt;
    next_lp_done = 1'b0;
    if (restart)
      next_lp_cnt = 16'h0000;
    else if (sens_rise)
    begin
      if (lp_cnt + 16'h0001 >= lp_len)
      begin
        next_lp_cnt = 16'h0000;
        next_lp_done = 1'b1;
      end
      else
        next_lp_cnt = lp_cnt + 16'h0001;
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lp_cnt <= 16'h0000;
      lp_done <= 1'b0;
    end
    else
    begin
      lp_cnt <= next_lp_cnt;
      lp_done <= next_lp_done;
    end
  end
  assign loss_conv_done_out = lp_done;

  // reference clock presence: lost if no edge within a window
  logic [7:0] ref_idle, next_ref_idle;
  logic ref_alive;
  assign ref_alive = ref_idle < `ICW_REF_TIMEOUT;
  always_comb
  begin
    next_ref_idle = ref_idle;
    if (ref_rise)
      next_ref_idle = 8'h00;
    else if (ref_alive)
      next_ref_idle = ref_idle + 8'h01;
  end
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      ref_idle <= `ICW_REF_TIMEOUT;
    else
      ref_idle <= next_ref_idle;
  end

  // high-res conversion: gate sensor edges over 16*count ref cycles, then 55 post
  icw_pkg::icw_hr_state_e hr_state, next_hr_state;
  logic [23:0] ref_cnt, next_ref_cnt, sens_cnt, next_sens_cnt;
  logic [23:0] next_result;
  logic hr_done, next_hr_done;
  logic [23:0] gate_len;
  logic [47:0] hr_ratio;
  assign gate_len = {4'h0, reference_count, 4'h0};
  // ratio at 2^24 scale kept wide so a full count cannot overflow
  assign hr_ratio = ({sens_cnt, 24'h000000} / {24'h000000, gate_len}) >> high_res_config[1:0];
  always_comb
  begin
    next_hr_state = hr_state;
    next_ref_cnt = ref_cnt;
    next_sens_cnt = sens_cnt;
    next_result = high_res_result;
    next_hr_done = 1'b0;
    if (!ref_alive)
    begin
      next_hr_state = icw_pkg::HR_IDLE;
      next_result = 24'h000000;
    end
    else if (restart || oscillation_lost_flag)
    begin
      // no result is built while the tank is dead
      next_hr_state = icw_pkg::HR_IDLE;
      next_result = `ICW_RESULT_ALL_ONES;
    end
    else
    begin
      case (hr_state)
        icw_pkg::HR_IDLE:
        begin
          next_ref_cnt = 24'h000000;
          next_sens_cnt = 24'h000000;
          if (ref_rise && reference_count != 16'h0000)
            next_hr_state = icw_pkg::HR_COUNT;
        end
        icw_pkg::HR_COUNT:
        begin
          if (sens_rise)
            next_sens_cnt = sens_cnt + 24'h000001;
          if (ref_rise)
            next_ref_cnt = ref_cnt + 24'h000001;
          if (ref_rise && ref_cnt + 24'h000001 >= gate_len)
          begin
            next_ref_cnt = 24'h000000;
            next_hr_state = icw_pkg::HR_POST;
          end
        end
        icw_pkg::HR_POST:
        begin
          if (ref_rise)
            next_ref_cnt = ref_cnt + 24'h000001;
          if (ref_rise && ref_cnt + 24'h000001 >= `ICW_POST_CYCLES)
          begin
            // ratio scaled by divider; offset removed at weight 256
            next_result = hr_ratio[23:0] - {result_offset, 8'h00};
            next_hr_done = 1'b1;
            next_ref_cnt = 24'h000000;
            next_sens_cnt = 24'h000000;
            // finishing edge opens the next gate, so a conversion is 16*count+55
            if (reference_count != 16'h0000)
              next_hr_state = icw_pkg::HR_COUNT;
            else
              next_hr_state = icw_pkg::HR_IDLE;
          end
        end
        default: next_hr_state = icw_pkg::HR_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hr_state <= icw_pkg::HR_IDLE;
      ref_cnt <= 24'h000000;
      sens_cnt <= 24'h000000;
      high_res_result <= 24'h000000;
      hr_done <= 1'b0;
    end
    else
    begin
      hr_state <= next_hr_state;
      ref_cnt <= next_ref_cnt;
      sens_cnt <= next_sens_cnt;
      high_res_result <= next_result;
      hr_done <= next_hr_done;
    end
  end
  assign hr_conv_done_out = hr_done;

  a_restart_sets_flag: assert property (@(posedge core_clk_in) disable iff (rst_in)
    restart |-> oscillation_lost_flag) else $error("restart without lost flag");
  a_restart_ones: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (restart && ref_alive) |=> high_res_result == `ICW_RESULT_ALL_ONES)
    else $error("result not all ones after restart");
  a_restart_aborts: assert property (@(posedge core_clk_in) disable iff (rst_in)
    restart |=> (lp_cnt == 16'h0000 && !hr_done)) else $error("conversion survived restart");
  a_noref_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !ref_alive |=> high_res_result == 24'h000000) else $error("result nonzero without ref");
  a_noref_idle: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !ref_alive |=> hr_state == icw_pkg::HR_IDLE) else $error("conversion without ref clock");
  a_divider_bits: assert property (@(posedge core_clk_in) disable iff (rst_in)
    high_res_config[7:2] == 6'h00) else $error("divider field wide");
  a_lost_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (reg_addr_in == `ICW_A_STATUS) |-> reg_rdata_out[`ICW_LOSTFLAG_BIT] == oscillation_lost_flag)
    else $error("status bit mismatch");
  a_lp_done_count: assert property (@(posedge core_clk_in) disable iff (rst_in)
    lp_done |-> lp_cnt == 16'h0000) else $error("done with count left");
  a_wd_limit: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(restart) |-> $past(wd_cnt) >= wd_limit) else $error("early watchdog");
endmodule // icw_timing_watchdog

// ==== icw_sensor_model.sv ====
// tank and reference source on the far side of the sensor pins
module icw_sensor_model #(
  parameter int OSC_HALF = 60,
  parameter int REF_HALF = 37
) (
  input wire logic osc_en_in,
  input wire logic ref_en_in,
  output logic sensor_osc_out,
  output logic ref_clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sensor_osc_out = 1'b0;
  initial ref_clk_out = 1'b0;
  // a stalled tank rests low, so no edge can fake oscillation
  always #(OSC_HALF) sensor_osc_out = osc_en_in ? ~sensor_osc_out : 1'b0;
  // unused reference pin is tied to ground
  always #(REF_HALF) ref_clk_out = ref_en_in ? ~ref_clk_out : 1'b0;
endmodule // icw_sensor_model

// ==== inductive_conversion_timing_watchdog_tb.sv ====
module inductive_conversion_timing_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out, loss_range_out, time_constant_out;
  logic sensor_osc_in, reference_clock_input_in, osc_restart_out;
  logic loss_conv_done_out, hr_conv_done_out;
  logic fixed_drive_optimise_out, drive_status_report_out;
  logic osc_en = 1'b0;
  logic ref_en = 1'b0;
  logic [2:0] ev;
  logic [23:0] r0, r1;
  int fail_count = 0;
  int n_tests = 0;
  int ev_n[3];
  time ev_t[3];
  time t0;
  int codes[3] = '{0, 3, 7};
  int shs[3] = '{0, 1, 5};
  int flds[2] = '{0, 4};
  logic [7:0] addrs[14] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h0C, 8'h30, 8'h31, 8'h32,
    8'h33, 8'h34, 8'h38, 8'h39, 8'h3A, 8'h01};

  always #10 core_clk_in = ~core_clk_in;

  icw_timing_watchdog dut_u (.core_clk_in, .rst_in, .reg_wr_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .sensor_osc_in, .reference_clock_input_in,
    .osc_restart_out, .loss_conv_done_out, .hr_conv_done_out, .loss_range_out,
    .time_constant_out, .fixed_drive_optimise_out, .drive_status_report_out);

  icw_sensor_model sens_u (.osc_en_in(osc_en), .ref_en_in(ref_en),
    .sensor_osc_out(sensor_osc_in), .ref_clk_out(reference_clock_input_in));

  // pulse counters with time stamps: loss done, high-res done, restart
  assign ev = {osc_restart_out, hr_conv_done_out, loss_conv_done_out};
  always @(posedge core_clk_in)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (ev[i] === 1'b1)
      begin
        ev_n[i]++;
        ev_t[i] = $time;
      end
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string what);
    @(negedge core_clk_in);
    reg_addr_in = a;
    #1;
    check({16'h0, reg_rdata_out}, {16'h0, e}, what);
  endtask

  // read right after a completion so no new result lands mid-read
  task automatic rd24(output logic [23:0] v);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge core_clk_in);
      reg_addr_in = 8'h38 + 8'(i);
      #1;
      v[8*i +: 8] = reg_rdata_out;
    end
  endtask

  task automatic wait_ev(input int k, input int lim);
    int c;
    c = ev_n[k];
    for (int i = 0; i < lim && ev_n[k] == c; i++)
      @(posedge core_clk_in);
    check({23'h0, ev_n[k] != c}, 24'h1, "event missing");
  endtask

  task automatic gap(input int k, input int lim, input time exp, input string what);
    time t;
    wait_ev(k, lim);
    t = ev_t[k];
    wait_ev(k, lim);
    check({23'h0, (ev_t[k] - t + 60 >= exp) && (ev_t[k] - t <= exp + 60)}, 24'h1, what);
  endtask

  task automatic stop_test();
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #2000000;
    fail_count++;
    stop_test();
  end

  initial
  begin
    repeat (6) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    foreach (addrs[i]) rdc(addrs[i], 8'h00, "reset value");
    wr(8'h01, 8'hA5);
    wr(8'h03, 8'hC7);
    wr(8'h05, 8'h01);
    wr(8'h0C, 8'h01);
    wr(8'h34, 8'hFF);
    wr(8'h30, 8'h04);
    wr(8'h31, 8'h12);
    wr(8'h38, 8'hFF);
    wr(8'h02, 8'h5A);
    rdc(8'h01, 8'hA5, "loss range");
    rdc(8'h34, 8'h03, "divider field");
    rdc(8'h30, 8'h04, "count low");
    rdc(8'h31, 8'h12, "count high");
    wr(8'h30, 8'hFF);
    wr(8'h31, 8'hFF);
    rdc(8'h30, 8'hFF, "count max low");
    rdc(8'h31, 8'hFF, "count max high");
    wr(8'h30, 8'h04);
    rdc(8'h38, 8'h00, "read-only result");
    check({6'h0, fixed_drive_optimise_out, drive_status_report_out, loss_range_out,
      time_constant_out}, 24'h03A5C7, "config outputs");
    wr(8'h05, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h34, 8'h00);
    check({22'h0, fixed_drive_optimise_out, drive_status_report_out}, 24'h0, "drive bits");
    // sensor runs, reference pin grounded
    osc_en = 1'b1;
    foreach (codes[i])
    begin
      wr(8'h04, 8'(codes[i]));
      wait_ev(0, 20000);
      gap(0, 20000, 120 * (64 << shs[i]), "loss conversion length");
    end
    check(24'(ev_n[1]), 24'h0, "high-res without reference");
    rd24(r0);
    check(r0, 24'h0, "result without reference");
    ref_en = 1'b1;
    wr(8'h31, 8'h00);
    wait_ev(1, 2000);
    gap(1, 2000, 119 * 74, "high-res length");
    rd24(r0);
    check({23'h0, r0 != 24'h0 && r0 != 24'hFFFFFF}, 24'h1, "valid result");
    wr(8'h34, 8'h01);
    wait_ev(1, 2000);
    wait_ev(1, 2000);
    rd24(r1);
    check({23'h0, r1 + r0 / 16 >= r0 / 2 && r1 <= r0 / 2 + r0 / 16}, 24'h1, "divider");
    foreach (flds[i])
    begin
      wr(8'h04, 8'(flds[i] << 4));
      wait_ev(0, 2000);
      @(negedge core_clk_in);
      osc_en = 1'b0;
      t0 = $time;
      wait_ev(2, 2000);
      check({23'h0, ev_t[2] - t0 + 200 >= 20 * (1024 >> flds[i]) &&
        ev_t[2] - t0 <= 20 * (1024 >> flds[i]) + 200}, 24'h1, "watchdog interval");
      rdc(8'h20, 8'h80, "lost flag");
      wait_ev(2, 2000);
      rd24(r0);
      check(r0, 24'hFFFFFF, "result after loss");
      @(negedge core_clk_in);
      osc_en = 1'b1;
      t0 = $time;
      wait_ev(0, 2000);
      check({23'h0, ev_t[0] - t0 + 60 >= 64 * 120}, 24'h1, "conversion restarted");
      rdc(8'h20, 8'h00, "lost flag cleared");
    end
    stop_test();
  end
endmodule // inductive_conversion_timing_watchdog_tb
